// *** bench/mtp_stage_model.sv ***
// model of the power stage and encoder side that feeds the unit's inputs
`default_nettype none
module mtp_stage_model
(
    input wire logic clk_i,
    input wire logic fault_req_i,
    input wire logic dir_up_i,
    input wire logic ext_run_i,
    output logic fault_n_o,
    output logic dir_o,
    output logic ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg = 2'h0;
    // pulled-up fault line; external clock stands still while not running
    initial
    begin
        fault_n_o = 1'b1;
        dir_o = 1'b1;
        ext_clk_o = 1'b0;
    end
    always @(posedge clk_i)
    begin
        fault_n_o <= !fault_req_i;
        dir_o <= dir_up_i;
        div_reg <= ext_run_i ? div_reg + 2'h1 : 2'h0;
        ext_clk_o <= ext_run_i & div_reg[1];
    end
endmodule
`default_nettype wire

// *** bench/mtp_unit_assertions.sv ***
// checker: bus and protection properties seen at the unit's ports
`default_nettype none
module mtp_unit_assertions
    import mtp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic power_protect_fault_input_n_i,
    input wire mtp_pkg::mtp_pins_s pwm_o,
    input wire logic irq_o
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] low_run_reg;
    logic [4:0] low_run_next;
    // low run on the fault pin, saturating so a long fault never wraps
    assign low_run_next = power_protect_fault_input_n_i ? 5'h00 :
        ((low_run_reg == 5'h1f) ? low_run_reg : low_run_reg + 5'h01);
    always_ff @(posedge clk_i)
        low_run_reg <= rst_i ? 5'h00 : low_run_next;
    // bus answers: one pulse, one cycle after the request is taken
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data changed outside an answer");
    chk_upper_zero: assert property (wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && pwm_o.oe == 8'h00 && !irq_o)
        else $error("outputs active right after reset");
    // protection: all pins float together, and a long fault floats them
    chk_oe_uniform: assert property (pwm_o.oe == 8'h00 || pwm_o.oe == 8'hff)
        else $error("pin enables differ");
    chk_fault_off: assert property (low_run_reg >= 5'h12 |-> pwm_o.oe == 8'h00)
        else $error("pins driven during a qualified fault");
endmodule
bind mtp_unit mtp_unit_assertions u_mtp_unit_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .power_protect_fault_input_n_i(power_protect_fault_input_n_i), .pwm_o(pwm_o),
    .irq_o(irq_o));
`default_nettype wire

// *** bench/test_motor_event_timer_pwm_unit.sv ***
// testbench: register access, counting, flags and protection input of the unit
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_motor_event_timer_pwm_unit
    import mtp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [31:0] q2;
    logic ack;
    logic irq;
    mtp_pins_s pins;
    logic fault_req = 1'b0;
    logic dir_up = 1'b1;
    logic ext_run = 1'b0;
    logic fault_n;
    logic dir;
    logic ext_clk;
    int fails = 0;
    int cmp_count = 0;
    int n;
    logic [5:0] idx_tab [6] = '{T1_COUNT_IDX, T1_COMPARE_IDX, T1_PERIOD_IDX,
        T2_CONTROL_IDX, DEADBAND_IDX, 6'h3f};
    logic [15:0] val_tab [6] = '{16'ha5c3, 16'h0123, 16'hfedc, 16'h0003, 16'h01ff, 16'hbeef};
    logic [15:0] exp_tab [6] = '{16'ha5c3, 16'h0123, 16'hfedc, 16'h0003, 16'h00ff, 16'h0000};
    always #2 clk_i = ~clk_i;
    mtp_unit u_mtp_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .count_direction_input_i(dir), .external_timer_clock_a_i(ext_clk),
        .power_protect_fault_input_n_i(fault_n), .pwm_o(pins), .irq_o(irq));
    mtp_stage_model u_mtp_stage_model (.clk_i(clk_i), .fault_req_i(fault_req),
        .dir_up_i(dir_up), .ext_run_i(ext_run), .fault_n_o(fault_n), .dir_o(dir),
        .ext_clk_o(ext_clk));
    // ****************************************************************
    // bus tasks: hold the request until ack is seen, release after it
    // ****************************************************************
    task automatic wb_io(input logic w, input logic [5:0] idx, input logic [15:0] d,
        input logic [3:0] s, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= {16'h0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        wb_io(1'b1, idx, d, 4'hf, q);
    endtask
    task automatic rd(input logic [5:0] idx);
        wb_io(1'b0, idx, 16'h0000, 4'hf, q);
    endtask
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: the sequence needs a few thousand cycles at most
    initial
    begin
        #100000;
        fails++;
        end_of_test();
    end
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(T1_PERIOD_IDX);
        `CHK(q[15:0], PERIOD_RESET)
        rd(CMP_CTRL_IDX);
        `CHK(q[CC_FAULT_BIT], 1'b1)
        for (int i = 0; i < 6; i++)
        begin
            wr(idx_tab[i], val_tab[i]);
            rd(idx_tab[i]);
            `CHK(q, {16'h0000, exp_tab[i]})
        end
        wb_io(1'b1, T1_COUNT_IDX, 16'h1111, 4'hc, q);
        rd(T1_COUNT_IDX);
        `CHK(q[15:0], 16'ha5c3)
        // directional mode: count follows the direction pin both ways
        wr(T2_COUNT_IDX, 16'h0100);
        dir_up <= 1'b0;
        wr(T2_CONTROL_IDX, 16'h1840);
        repeat (20) @(posedge clk_i);
        rd(T2_COUNT_IDX);
        `CHK(q[15:0] < 16'h0100, 1'b1)
        dir_up <= 1'b1;
        q2 = q;
        repeat (20) @(posedge clk_i);
        rd(T2_COUNT_IDX);
        `CHK(q[15:0] > q2[15:0], 1'b1)
        // external clock: sixteen edges, then the count stands still
        wr(T2_CONTROL_IDX, 16'h0000);
        wr(T2_COUNT_IDX, 16'h0000);
        wr(T2_CONTROL_IDX, 16'h1050);
        ext_run <= 1'b1;
        repeat (64) @(posedge clk_i);
        ext_run <= 1'b0;
        repeat (8) @(posedge clk_i);
        rd(T2_COUNT_IDX);
        q2 = q;
        `CHK(q2[15:0], 16'h0010)
        repeat (16) @(posedge clk_i);
        rd(T2_COUNT_IDX);
        `CHK(q, q2)
        // period match flag raises the line, mask and write-one clear it
        wr(T1_COUNT_IDX, 16'h0000);
        wr(T1_PERIOD_IDX, 16'h0010);
        wr(IRQ_MASK_IDX, 16'h0008);
        wr(T1_CONTROL_IDX, 16'h1040);
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        `CHK(irq, 1'b1)
        rd(IRQ_FLAG_IDX);
        `CHK(q[3], 1'b1)
        wr(IRQ_MASK_IDX, 16'h0000);
        @(negedge clk_i);
        `CHK(irq, 1'b0)
        wr(T1_CONTROL_IDX, 16'h0000);
        wr(IRQ_FLAG_IDX, 16'h00ff);
        rd(IRQ_FLAG_IDX);
        `CHK(q[15:0], 16'h0000)
        // forced pin levels: the action word loads while timer 1 sits at zero
        wr(T1_COUNT_IDX, 16'h0000);
        wr(ACTION_IDX, 16'h0c00);
        rd(ACTION_IDX);
        `CHK({q[15:0], pins.level}, 24'h0c0020)
        // protection input: short glitch ignored, long fault floats pins
        wr(CMP_CTRL_IDX, 16'h8000);
        @(negedge clk_i);
        `CHK(pins.oe, 8'hff)
        fault_req <= 1'b1;
        repeat (4) @(posedge clk_i);
        fault_req <= 1'b0;
        repeat (20) @(posedge clk_i);
        rd(CMP_CTRL_IDX);
        `CHK({q[CC_FAULT_BIT], pins.oe}, 9'h1ff)
        wr(SYS_CTRL_IDX, 16'h0040);
        fault_req <= 1'b1;
        repeat (10) @(posedge clk_i);
        rd(CMP_CTRL_IDX);
        `CHK(q[CC_FAULT_BIT], 1'b1)
        repeat (10) @(posedge clk_i);
        rd(CMP_CTRL_IDX);
        `CHK({q[CC_FAULT_BIT], pins.oe}, 9'h000)
        fault_req <= 1'b0;
        wr(SYS_CTRL_IDX, 16'h0000);
        repeat (20) @(posedge clk_i);
        fault_req <= 1'b1;
        repeat (10) @(posedge clk_i);
        rd(CMP_CTRL_IDX);
        `CHK(q[CC_FAULT_BIT], 1'b0)
        fault_req <= 1'b0;
        end_of_test();
    end
endmodule
`default_nettype wire

// *** hdl/mtp_pkg.sv ***
// package: register map, field layout and constants of the motor event timer pwm unit
package mtp_pkg;
    // ****************************************************************
    // register word offsets (byte address = 4 * index)
    // ****************************************************************
    localparam logic [5:0] T1_COUNT_IDX = 6'h00;
    localparam logic [5:0] T1_COMPARE_IDX = 6'h01;
    localparam logic [5:0] T1_PERIOD_IDX = 6'h02;
    localparam logic [5:0] T1_CONTROL_IDX = 6'h03;
    localparam logic [5:0] T2_COUNT_IDX = 6'h04;
    localparam logic [5:0] T2_COMPARE_IDX = 6'h05;
    localparam logic [5:0] T2_PERIOD_IDX = 6'h06;
    localparam logic [5:0] T2_CONTROL_IDX = 6'h07;
    localparam logic [5:0] CMP_CTRL_IDX = 6'h08;
    localparam logic [5:0] ACTION_IDX = 6'h09;
    localparam logic [5:0] DEADBAND_IDX = 6'h0a;
    localparam logic [5:0] CMP1_IDX = 6'h0b;
    localparam logic [5:0] CMP2_IDX = 6'h0c;
    localparam logic [5:0] CMP3_IDX = 6'h0d;
    localparam logic [5:0] IRQ_FLAG_IDX = 6'h0e;
    localparam logic [5:0] IRQ_MASK_IDX = 6'h0f;
    localparam logic [5:0] SYS_CTRL_IDX = 6'h10;

    // ****************************************************************
    // timer control word fields
    // ****************************************************************
    localparam int TC_MODE_LSB = 11;    // [12:11] counting mode
    localparam int TC_PRESC_LSB = 8;    // [10:8] prescale 2^n
    localparam int TC_ENABLE_BIT = 6;
    localparam int TC_EXTCLK_BIT = 4;
    localparam int TC_SYNC_BIT = 7;     // timer 2 only: start with timer 1
    localparam int TC_CMPEN_BIT = 1;
    localparam int TC_POL_BIT = 0;

    // ****************************************************************
    // compare control and system control fields
    // ****************************************************************
    localparam int CC_ENABLE_BIT = 15;
    localparam int CC_FAULT_BIT = 8;    // qualified protection level
    localparam int CC_DBEN_LSB = 0;     // [2:0] deadband enable per unit
    localparam int CC_SVM_BIT = 12;     // four-space-vector pattern
    localparam int SC_QUAL_LONG_BIT = 6;
    localparam logic [15:0] CMP_CTRL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;

    // ****************************************************************
    // qualifier lengths in clock edges
    // ****************************************************************
    localparam logic [3:0] QUAL_SHORT = 4'h6;
    localparam logic [3:0] QUAL_LONG = 4'hc;

    // ****************************************************************
    // counting modes and output actions
    // ****************************************************************
    typedef enum logic [1:0] {MODE_STOP, MODE_UPDOWN, MODE_UP, MODE_DIR} mtp_mode_e;
    localparam logic [1:0] ACT_LOW = 2'h0;
    localparam logic [1:0] ACT_ACTIVE_LOW = 2'h1;
    localparam logic [1:0] ACT_ACTIVE_HIGH = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;

    // one pin group: level, output enable
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe;
    } mtp_pins_s;
endpackage

// *** hdl/mtp_unit.sv ***
// motor event timer pwm unit: two timers, three compare units, deadband, protection
// Operation
// - two 16-bit up/down readable writable counters
// - timer compare register with shadow copy
// - timer period register with shadow copy
// - 16-bit readable writable timer control word
// - internal or external clock through prescaler
// - underflow overflow compare period maskable flags
// - direction pin steers directional up/down mode
// - timers run independently or synchronized
// - two continuous modes, up and up/down
// - timer 1 is base for compare units
// - each timer compare drives one pwm output
// - three compare units give six outputs
// - each of six outputs configured independently
// - compare unit registers double-buffered
// - three 8-bit deadband counters, shared compare
// - deadband enabled per compare unit
// - each unit yields complementary pair with deadzone
// - action control register double-buffered
// - smallest nonzero deadband is one clock
// - asymmetric, symmetric and space-vector patterns
// - qualified low fault tristates all pwm pins
// - qualified fault level readable at bit 8
// - qualifier needs stable level for n edges
// - system bit picks six or twelve edges
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`default_nettype none
module mtp_unit
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic count_direction_input_i,
    input wire logic external_timer_clock_a_i,
    input wire logic power_protect_fault_input_n_i,
    output mtp_pkg::mtp_pins_s pwm_o,
    output logic irq_o
);
    import mtp_pkg::*;
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic ext_clk_prev_reg;
    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            ext_clk_prev_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= {power_protect_fault_input_n_i, external_timer_clock_a_i,
                          count_direction_input_i};
            sync2_reg <= sync1_reg;
            ext_clk_prev_reg <= sync2_reg[1];
        end
    end
    wire dir_up = sync2_reg[0];
    wire ext_rise = sync2_reg[1] & ~ext_clk_prev_reg;
    wire fault_pin_n = sync2_reg[2];
    // ****************************************************************
    // bus slave and registers
    // ****************************************************************
    logic [15:0] tctl_reg [2];
    logic [15:0] tcmp_sh_reg [2];
    logic [15:0] tcmp_reg [2];
    logic [15:0] tper_sh_reg [2];
    logic [15:0] tper_reg [2];
    logic [15:0] tcnt_reg [2];
    logic [15:0] ccmp_sh_reg [3];
    logic [15:0] ccmp_reg [3];
    logic [15:0] cctl_reg;
    logic [15:0] act_sh_reg;
    logic [15:0] act_reg;
    logic [7:0] db_reg;
    logic [7:0] iflag_reg;
    logic [7:0] imask_reg;
    logic sysctl_reg;
    logic fault_q_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    wire [5:0] idx = wb_adr_i[7:2];
    wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr = req & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
    wire [15:0] wd = wb_dat_i[15:0];
    wire wr_flag = wr & (idx == IRQ_FLAG_IDX);
    wire [15:0] cctl_rd = {cctl_reg[15:9], fault_q_reg, cctl_reg[7:0]};
    // read multiplexer; unmapped words read zero
    logic [15:0] rmux;
    always_comb
    begin
        rmux = 16'h0000;
        if (idx == T1_COUNT_IDX) rmux = tcnt_reg[0];
        else if (idx == T1_COMPARE_IDX) rmux = tcmp_sh_reg[0];
        else if (idx == T1_PERIOD_IDX) rmux = tper_sh_reg[0];
        else if (idx == T1_CONTROL_IDX) rmux = tctl_reg[0];
        else if (idx == T2_COUNT_IDX) rmux = tcnt_reg[1];
        else if (idx == T2_COMPARE_IDX) rmux = tcmp_sh_reg[1];
        else if (idx == T2_PERIOD_IDX) rmux = tper_sh_reg[1];
        else if (idx == T2_CONTROL_IDX) rmux = tctl_reg[1];
        else if (idx == CMP_CTRL_IDX) rmux = cctl_rd;
        else if (idx == ACTION_IDX) rmux = act_sh_reg;
        else if (idx == DEADBAND_IDX) rmux = {8'h00, db_reg};
        else if (idx == CMP1_IDX) rmux = ccmp_sh_reg[0];
        else if (idx == CMP2_IDX) rmux = ccmp_sh_reg[1];
        else if (idx == CMP3_IDX) rmux = ccmp_sh_reg[2];
        else if (idx == IRQ_FLAG_IDX) rmux = {8'h00, iflag_reg};
        else if (idx == IRQ_MASK_IDX) rmux = {8'h00, imask_reg};
        else if (idx == SYS_CTRL_IDX) rmux = {9'h000, sysctl_reg, 6'h00};
    end
    // single-cycle ack, dropped the cycle after it was given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg <= req;
            if (req) rdata_reg <= {16'h0000, rmux};
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    // configuration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cctl_reg <= CMP_CTRL_RESET;
            act_sh_reg <= 16'h0000;
            db_reg <= 8'h00;
            imask_reg <= 8'h00;
            sysctl_reg <= 1'b0;
        end
        else if (wr)
        begin
            if (idx == CMP_CTRL_IDX) cctl_reg <= wd;
            if (idx == ACTION_IDX) act_sh_reg <= wd;
            if (idx == DEADBAND_IDX) db_reg <= wd[7:0];
            if (idx == IRQ_MASK_IDX) imask_reg <= wd[7:0];
            if (idx == SYS_CTRL_IDX) sysctl_reg <= wd[SC_QUAL_LONG_BIT];
        end
    end
    // ****************************************************************
    // general-purpose timers
    // ****************************************************************
    logic t1_zero;
    logic t1_period;
    logic t1_down;
    logic [7:0] ev;
    logic [1:0] tpwm;
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_timer
            logic [6:0] pre_reg;
            logic down_reg;
            logic out_reg;
            logic [15:0] cnt_next;
            logic down_next;
            wire [1:0] mode = tctl_reg[g][TC_MODE_LSB +: 2];
            wire [2:0] presc = tctl_reg[g][TC_PRESC_LSB +: 3];
            // timer 2 may be started by the enable of timer 1
            wire run = (g == 1 && tctl_reg[1][TC_SYNC_BIT]) ?
                       tctl_reg[0][TC_ENABLE_BIT] : tctl_reg[g][TC_ENABLE_BIT];
            wire src = tctl_reg[g][TC_EXTCLK_BIT] ? ext_rise : 1'b1;
            wire [6:0] pmask = 7'((8'h01 << presc) - 8'h01);
            wire tick = run && mode != MODE_STOP && src && ((pre_reg & pmask) == pmask);
            wire at_per = tcnt_reg[g] == tper_reg[g];
            wire at_zero = tcnt_reg[g] == 16'h0000;
            wire at_cmp = tcnt_reg[g] == tcmp_reg[g];
            wire wr_cnt = wr & (idx == 6'(4 * g));
            // counting modes
            always_comb
            begin
                cnt_next = tcnt_reg[g];
                down_next = down_reg;
                case (mode)
                    MODE_UP:
                    begin
                        cnt_next = at_per ? 16'h0000 : 16'(tcnt_reg[g] + 16'h0001);
                        down_next = 1'b0;
                    end
                    MODE_UPDOWN:
                    begin
                        if (at_per) down_next = 1'b1;
                        else if (at_zero) down_next = 1'b0;
                        cnt_next = down_next ? 16'(tcnt_reg[g] - 16'h0001) :
                                   16'(tcnt_reg[g] + 16'h0001);
                    end
                    MODE_DIR:
                    begin
                        down_next = ~dir_up;
                        if (dir_up) cnt_next = at_per ? 16'h0000 : 16'(tcnt_reg[g] + 16'h0001);
                        else cnt_next = at_zero ? tper_reg[g] : 16'(tcnt_reg[g] - 16'h0001);
                    end
                    default: cnt_next = tcnt_reg[g];
                endcase
            end
            // counter, shadows reload at zero so new values start a fresh period
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    tcnt_reg[g] <= 16'h0000;
                    tctl_reg[g] <= 16'h0000;
                    tcmp_sh_reg[g] <= 16'h0000;
                    tcmp_reg[g] <= 16'h0000;
                    tper_sh_reg[g] <= PERIOD_RESET;
                    tper_reg[g] <= PERIOD_RESET;
                    pre_reg <= 7'h00;
                    down_reg <= 1'b0;
                end
                else
                begin
                    if (src && run) pre_reg <= 7'(pre_reg + 7'h01);
                    if (wr_cnt) tcnt_reg[g] <= wd;
                    else if (tick)
                    begin
                        tcnt_reg[g] <= cnt_next;
                        down_reg <= down_next;
                    end
                    if (wr && idx == 6'(4 * g + 3)) tctl_reg[g] <= wd;
                    if (wr && idx == 6'(4 * g + 1)) tcmp_sh_reg[g] <= wd;
                    if (wr && idx == 6'(4 * g + 2)) tper_sh_reg[g] <= wd;
                    if (at_zero || mode == MODE_STOP)
                    begin
                        tcmp_reg[g] <= tcmp_sh_reg[g];
                        tper_reg[g] <= tper_sh_reg[g];
                    end
                end
            end
            // timer compare output: set at compare match, cleared at zero
            always_ff @(posedge clk_i)
            begin
                if (rst_i) out_reg <= 1'b0;
                else if (at_zero) out_reg <= 1'b0;
                else if (at_cmp) out_reg <= 1'b1;
            end
            assign tpwm[g] = (out_reg ^ ~tctl_reg[g][TC_POL_BIT]) &
                             tctl_reg[g][TC_CMPEN_BIT];
            // events: underflow, overflow, compare, period
            assign ev[4 * g + 0] = tick & at_zero & down_reg;
            assign ev[4 * g + 1] = tick & (tcnt_reg[g] == 16'hffff) & ~down_reg;
            assign ev[4 * g + 2] = tick & at_cmp;
            assign ev[4 * g + 3] = tick & at_per;
            if (g == 0)
            begin : gen_base
                assign t1_zero = at_zero;
                assign t1_period = at_per;
                assign t1_down = down_reg;
            end
        end
    endgenerate
    // sticky flags, set wins over write-one-to-clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i) iflag_reg <= 8'h00;
        else iflag_reg <= (iflag_reg & ~(wr_flag ? wd[7:0] : 8'h00)) | ev;
    end
    assign irq_o = |(iflag_reg & imask_reg);
    // ****************************************************************
    // full compare units with deadband
    // ****************************************************************
    logic [5:0] cmp_pin;
    logic [3:0] svm_sector;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            act_reg <= 16'h0000;
            svm_sector <= 4'h0;
        end
        else if (t1_zero || t1_period)
        begin
            act_reg <= act_sh_reg;
            svm_sector <= act_sh_reg[15:12];
        end
    end
    generate
        for (g = 0; g < 3; g++)
        begin : gen_cmp
            logic raw_reg;
            logic [7:0] db_cnt_reg;
            logic hi_reg;
            logic lo_reg;
            wire t1_cmp = tcnt_reg[0] == ccmp_reg[g];
            wire db_on = cctl_reg[CC_DBEN_LSB + g] && db_reg != 8'h00;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    ccmp_sh_reg[g] <= 16'h0000;
                    ccmp_reg[g] <= 16'h0000;
                    raw_reg <= 1'b0;
                end
                else
                begin
                    if (wr && idx == 6'(CMP1_IDX + 6'(g))) ccmp_sh_reg[g] <= wd;
                    if (t1_zero || t1_period) ccmp_reg[g] <= ccmp_sh_reg[g];
                    // asymmetric: set at compare clear at zero; symmetric toggles
                    if (t1_zero && !t1_down) raw_reg <= 1'b0;
                    else if (t1_cmp) raw_reg <= (tctl_reg[0][TC_MODE_LSB +: 2] == MODE_UPDOWN) ?
                                               ~t1_down : 1'b1;
                end
            end
            // deadband: an edge outside the dead zone starts the counter, the rising side waits
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    db_cnt_reg <= 8'h00;
                    hi_reg <= 1'b0;
                    lo_reg <= 1'b1;
                end
                else if (!db_on)
                begin
                    db_cnt_reg <= 8'h00;
                    hi_reg <= raw_reg;
                    lo_reg <= ~raw_reg;
                end
                else if (raw_reg != hi_reg && raw_reg == lo_reg)
                begin
                    // both sides off during the dead zone, minimum one clock
                    hi_reg <= 1'b0;
                    lo_reg <= 1'b0;
                    db_cnt_reg <= 8'h01;
                end
                else if (db_cnt_reg != 8'h00)
                begin
                    db_cnt_reg <= 8'(db_cnt_reg + 8'h01);
                    if (db_cnt_reg >= db_reg)
                    begin
                        db_cnt_reg <= 8'h00;
                        hi_reg <= raw_reg;
                        lo_reg <= ~raw_reg;
                    end
                end
            end
            // per-pin action; space-vector pattern picks the sector bits
            for (genvar k = 0; k < 2; k++)
            begin : gen_pin
                wire [1:0] act = act_reg[4 * g + 2 * k +: 2];
                wire phase = cctl_reg[CC_SVM_BIT] ?
                             (svm_sector[g] ^ (k == 1)) : (k == 0 ? hi_reg : lo_reg);
                assign cmp_pin[2 * g + k] = (act == ACT_HIGH) ? 1'b1 :
                                            (act == ACT_ACTIVE_HIGH) ? phase :
                                            (act == ACT_ACTIVE_LOW) ? ~phase : 1'b0;
            end
        end
    endgenerate
    // ****************************************************************
    // protection input qualifier
    // ****************************************************************
    logic [3:0] qual_cnt_reg;
    wire [3:0] qual_len = sysctl_reg ? QUAL_LONG : QUAL_SHORT;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            qual_cnt_reg <= 4'h0;
            fault_q_reg <= 1'b1;
        end
        else if (fault_pin_n == fault_q_reg) qual_cnt_reg <= 4'h0;
        else if (4'(qual_cnt_reg + 4'h1) >= qual_len)
        begin
            fault_q_reg <= fault_pin_n;
            qual_cnt_reg <= 4'h0;
        end
        else qual_cnt_reg <= 4'(qual_cnt_reg + 4'h1);
    end
    // output pins: registered levels, enables drop on a qualified fault
    logic [7:0] pin_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i) pin_reg <= 8'h00;
        else pin_reg <= {tpwm, cmp_pin};
    end
    wire pins_on = fault_q_reg & cctl_reg[CC_ENABLE_BIT];
    assign pwm_o.level = pin_reg;
    assign pwm_o.oe = pins_on ? 8'hff : 8'h00;
endmodule
`default_nettype wire
